// file: verilog/pwm_leb_pkg.sv
package pwm_leb_pkg;

	// ****************************************
	// register map, byte addresses
	// ****************************************
	localparam logic [7:0]  ADDR_CONTROL  = 8'h00;    // blanking_control
	localparam logic [7:0]  ADDR_DURATION = 8'h04;    // blanking length in clocks
	localparam logic [7:0]  ADDR_STATUS   = 8'h08;    // live state, read only

	// ****************************************
	// blanking_control field positions
	// ****************************************
	localparam int BIT_HI_RISE      = 15;             // hi_rise_trig_en
	localparam int BIT_HI_FALL      = 14;             // hi_fall_trig_en
	localparam int BIT_LO_RISE      = 13;             // lo_rise_trig_en
	localparam int BIT_LO_FALL      = 12;             // lo_fall_trig_en
	localparam int BIT_FAULT_BLANK  = 11;             // fault_blank_en
	localparam int BIT_CURLIM_BLANK = 10;             // curlim_blank_en
	localparam int BIT_SIG_HIGH     = 5;              // sel_sig_high_blank_en
	localparam int BIT_SIG_LOW      = 4;              // sel_sig_low_blank_en
	localparam int BIT_HI_OUT_HIGH  = 3;              // hi_out_high_blank_en
	localparam int BIT_HI_OUT_LOW   = 2;              // hi_out_low_blank_en

	// ****************************************
	// status field positions
	// ****************************************
	localparam int ST_LEB_ACTIVE    = 0;              // edge counter running
	localparam int ST_STATE_BLANK   = 1;              // state blanking condition
	localparam int ST_FAULT_RAW     = 2;              // synchronised fault input
	localparam int ST_CURLIM_RAW    = 3;              // synchronised current limit
	localparam int ST_FAULT_OUT     = 4;              // fault after blanking
	localparam int ST_CURLIM_OUT    = 5;              // current limit after blanking

	// ****************************************
	// reset values and masks
	// ****************************************
	localparam logic [15:0] CONTROL_RESET = 16'h0000; // all blanking off
	localparam logic [15:0] CONTROL_WMASK = 16'hFC3C; // implemented bits only

	// ****************************************
	// timing
	// ****************************************
	localparam int CLK_PERIOD_PS  = 5000;             // 200 MHz
	localparam int BLANK_TIME_NS  = 100;              // default blanking length
	localparam int BLANK_CYCLES   = (BLANK_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam logic [15:0] DURATION_RESET = 16'(BLANK_CYCLES);

endpackage

// file: verilog/leb_edge_detect.sv
`timescale 1ns/1ps
// rising / falling edge pulses for same-clock levels
module leb_edge_detect #(
	parameter int N = 2                  // number of levels watched
) (
	// clock and reset
	input  wire logic         clk_i,
	input  wire logic         rst_i,
	// levels in
	input  wire logic [N-1:0] level_i,
	// one-cycle edge pulses
	output logic      [N-1:0] rise_o,
	output logic      [N-1:0] fall_o
);

	// ****************************************
	// previous value per level
	// ****************************************
	logic [N-1:0] prev;                  // level one clock ago

	genvar g;
	generate
		for (g = 0; g < N; g++) begin : g_edge
			// remember last level; reset low so a level high at reset shows a rise
			always_ff @(posedge clk_i) begin
				if (rst_i) begin
					prev[g] <= 1'b0;
				end else begin
					prev[g] <= level_i[g];
				end
			end
			// pulses are combinational so the trigger lands in the edge cycle
			assign rise_o[g] = level_i[g] & ~prev[g];
			assign fall_o[g] = ~level_i[g] & prev[g];
		end
	endgenerate

endmodule

// file: verilog/leb_blank_counter.sv
`timescale 1ns/1ps
// retriggerable down counter; active while nonzero
module leb_blank_counter #(
	parameter int W = 16                 // counter width
) (
	// clock and reset
	input  wire logic         clk_i,
	input  wire logic         rst_i,
	// control
	input  wire logic         start_i,   // reload pulse
	input  wire logic [W-1:0] load_i,    // length in clocks
	// state
	output logic              active_o
);

	logic [W-1:0] count;                 // clocks left in window

	// reload wins over counting, so a new edge always restarts the full window
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			count <= '0;
		end else if (start_i) begin
			count <= load_i;
		end else if (count != '0) begin
			count <= count - W'(1);
		end
	end

	assign active_o = (count != '0);

endmodule

// file: verilog/pwm_leading_edge_blanking_ctrl.sv
`timescale 1ns/1ps
// Function
// - high-side rising edge starts blanking when enabled
// - high-side falling edge starts blanking when enabled
// - low-side rising edge starts blanking when enabled
// - low-side falling edge starts blanking when enabled
// - blanking window masks fault when enabled
// - blanking window masks current limit when enabled
// - blank while selected blanking signal high
// - blank while selected blanking signal low
// - blank while high-side output is high
// - blank while high-side output is low
module pwm_leading_edge_blanking_ctrl
	import pwm_leb_pkg::*;
#(
	parameter int CNT_W = 16             // blanking counter width
) (
	// clock and reset
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	// wishbone classic slave
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [7:0]  wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic      [31:0] wb_dat_o,
	output logic             wb_ack_o,
	// pwm outputs, same clock domain
	input  wire logic        pwm_high_side_out_i,
	input  wire logic        pwm_low_side_out_i,
	// asynchronous inputs
	input  wire logic        sel_blank_sig_i,
	input  wire logic        fault_raw_i,
	input  wire logic        curlim_raw_i,
	// blanked results and blanking state
	output logic             fault_o,
	output logic             curlim_o,
	output logic             leb_active_o,
	output logic             state_blank_o
);

	// ****************************************
	// declarations
	// ****************************************
	localparam int NSYNC = 3;            // blank signal, fault, current limit

	logic [15:0]      blanking_control;  // control register
	logic [CNT_W-1:0] blank_duration;    // window length in clocks
	logic [NSYNC-1:0] sync1;             // first synchroniser stage
	logic [NSYNC-1:0] sync2;             // second stage, safe to use
	logic             blank_sig_s;       // synchronised blanking signal
	logic             fault_s;           // synchronised fault
	logic             curlim_s;          // synchronised current limit
	logic [1:0]       rise;              // [1] high side, [0] low side
	logic [1:0]       fall;              // same order
	logic             trigger;           // enabled edge this cycle
	logic             leb_active;        // edge counter running
	logic             state_blank;       // any state condition true
	logic             bus_req;           // new wishbone request
	logic             wr_ctl;            // write hits control
	logic             wr_dur;            // write hits duration
	logic [31:0]      next_rdata;        // read mux
	logic [15:0]      status;            // live state word
	logic [15:0]      next_control;      // merged control write
	logic [CNT_W-1:0] next_duration;     // merged duration write

	// ****************************************
	// helper functions
	// ****************************************
	// input passes only when no blanking applies to it
	function automatic logic pass_input(input logic raw, input logic en,
	                                    input logic win, input logic st);
		pass_input = raw & ~(en & (win | st));
	endfunction

	// byte-lane merge for 16-bit registers, only writable bits change
	function automatic logic [15:0] merge16(input logic [15:0] old,
	                                        input logic [15:0] wdata,
	                                        input logic [1:0]  sel,
	                                        input logic [15:0] mask);
		logic [15:0] lanes;
		lanes   = {{8{sel[1]}}, {8{sel[0]}}} & mask;
		merge16 = (old & ~lanes) | (wdata & lanes);
	endfunction

	// ****************************************
	// input synchronisers
	// ****************************************
	// two flops for each outside level; stage one feeds stage two only
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			sync1 <= '0;
			sync2 <= '0;
		end else begin
			sync1 <= {sel_blank_sig_i, fault_raw_i, curlim_raw_i};
			sync2 <= sync1;
		end
	end

	assign blank_sig_s = sync2[2];
	assign fault_s     = sync2[1];
	assign curlim_s    = sync2[0];

	// ****************************************
	// edge detection on pwm outputs
	// ****************************************
	// pwm levels share our clock, so no synchroniser here
	leb_edge_detect #(
		.N       (2)
	) u_edges (
		.clk_i   (clk_i),
		.rst_i   (rst_i),
		.level_i ({pwm_high_side_out_i, pwm_low_side_out_i}),
		.rise_o  (rise),
		.fall_o  (fall)
	);

	// ****************************************
	// edge trigger selection
	// ****************************************
	always_comb begin
		trigger = 1'b0;
		if (blanking_control[BIT_HI_RISE] && rise[1]) begin
			trigger = 1'b1;
		end
		if (blanking_control[BIT_HI_FALL] && fall[1]) begin
			trigger = 1'b1;
		end
		if (blanking_control[BIT_LO_RISE] && rise[0]) begin
			trigger = 1'b1;
		end
		if (blanking_control[BIT_LO_FALL] && fall[0]) begin
			trigger = 1'b1;
		end
	end

	// ****************************************
	// leading-edge blanking counter
	// ****************************************
	// a zero duration makes edges harmless: the window never opens
	leb_blank_counter #(
		.W        (CNT_W)
	) u_counter (
		.clk_i    (clk_i),
		.rst_i    (rst_i),
		.start_i  (trigger),
		.load_i   (blank_duration),
		.active_o (leb_active)
	);

	// ****************************************
	// state blanking
	// ****************************************
	// levels, not edges: blanking follows the signal for as long as it holds
	always_comb begin
		state_blank = 1'b0;
		if (blanking_control[BIT_SIG_HIGH] && blank_sig_s) begin
			state_blank = 1'b1;
		end
		if (blanking_control[BIT_SIG_LOW] && !blank_sig_s) begin
			state_blank = 1'b1;
		end
		if (blanking_control[BIT_HI_OUT_HIGH] && pwm_high_side_out_i) begin
			state_blank = 1'b1;
		end
		if (blanking_control[BIT_HI_OUT_LOW] && !pwm_high_side_out_i) begin
			state_blank = 1'b1;
		end
	end

	// ****************************************
	// blanked outputs
	// ****************************************
	// state blanking reaches an input only through that input's enable;
	// the window and the state term share one mask so they cannot disagree
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			fault_o  <= 1'b0;
			curlim_o <= 1'b0;
		end else begin
			// masked fault reads inactive
			fault_o  <= pass_input(fault_s, blanking_control[BIT_FAULT_BLANK],
			                       leb_active, state_blank);
			// masked current limit reads inactive
			curlim_o <= pass_input(curlim_s, blanking_control[BIT_CURLIM_BLANK],
			                       leb_active, state_blank);
		end
	end

	// visible blanking state, registered for clean outputs
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			leb_active_o  <= 1'b0;
			state_blank_o <= 1'b0;
		end else begin
			leb_active_o  <= leb_active;
			state_blank_o <= state_blank;
		end
	end

	// ****************************************
	// wishbone decode
	// ****************************************
	// one request per cycle/strobe; the ack flop blocks a double take
	assign bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
	assign wr_ctl  = bus_req & wb_we_i & (wb_adr_i == ADDR_CONTROL);
	assign wr_dur  = bus_req & wb_we_i & (wb_adr_i == ADDR_DURATION);

	assign next_control  = merge16(blanking_control, wb_dat_i[15:0], wb_sel_i[1:0],
	                               CONTROL_WMASK);
	assign next_duration = CNT_W'(merge16(16'(blank_duration), wb_dat_i[15:0],
	                                      wb_sel_i[1:0], 16'hFFFF));

	// ****************************************
	// registers
	// ****************************************
	// control word steers all blanking logic
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			blanking_control <= CONTROL_RESET;
		end else if (wr_ctl) begin
			blanking_control <= next_control;
		end
	end

	// blanking length; reloaded by the next edge, not the running window
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			blank_duration <= CNT_W'(DURATION_RESET);
		end else if (wr_dur) begin
			blank_duration <= next_duration;
		end
	end

	// ****************************************
	// read path
	// ****************************************
	always_comb begin
		status                 = 16'h0000;
		status[ST_LEB_ACTIVE]  = leb_active;
		status[ST_STATE_BLANK] = state_blank;
		status[ST_FAULT_RAW]   = fault_s;
		status[ST_CURLIM_RAW]  = curlim_s;
		status[ST_FAULT_OUT]   = fault_o;
		status[ST_CURLIM_OUT]  = curlim_o;
	end

	always_comb begin
		next_rdata = 32'h0000_0000;             // unmapped reads as zero
		case (wb_adr_i)
			ADDR_CONTROL: begin
				next_rdata[15:0] = blanking_control;
			end
			ADDR_DURATION: begin
				next_rdata[15:0] = 16'(blank_duration);
			end
			ADDR_STATUS: begin
				next_rdata[15:0] = status;
			end
			default: begin
				next_rdata = 32'h0000_0000;
			end
		endcase
	end

	// ack every request one clock later, mapped or not; read data latched with it
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0000_0000;
		end else begin
			wb_ack_o <= bus_req;
			if (bus_req && !wb_we_i) begin
				wb_dat_o <= next_rdata;
			end
		end
	end

endmodule

// file: test/pwm_leb_asserts.sv
`timescale 1ns/1ps
module pwm_leb_checker
	import pwm_leb_pkg::*;
(
	// clock and reset
	input wire logic        clk_i,
	input wire logic        rst_i,
	// register bus
	input wire logic        wb_cyc_i,
	input wire logic        wb_stb_i,
	input wire logic        wb_we_i,
	input wire logic [7:0]  wb_adr_i,
	input wire logic [3:0]  wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic        wb_ack_o,
	// pwm levels and raw inputs
	input wire logic        pwm_high_side_out_i,
	input wire logic        pwm_low_side_out_i,
	input wire logic        sel_blank_sig_i,
	input wire logic        fault_raw_i,
	input wire logic        curlim_raw_i,
	// results
	input wire logic        fault_o,
	input wire logic        curlim_o,
	input wire logic        leb_active_o,
	input wire logic        state_blank_o
);
	// ****************
	// shadow state
	// ****************
	logic [15:0] ctl;  // copy of blanking_control
	logic        hi_q; // high side last cycle
	logic        lo_q; // low side last cycle
	logic [1:0]  age;  // edges since reset, stops at 3
	logic        trig; // enabled pwm edge this cycle
	assign trig = (ctl[15] && pwm_high_side_out_i && !hi_q)
		|| (ctl[14] && !pwm_high_side_out_i && hi_q)
		|| (ctl[13] && pwm_low_side_out_i && !lo_q)
		|| (ctl[12] && !pwm_low_side_out_i && lo_q);
	// follow control writes byte by byte, taken at the request edge
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ctl <= CONTROL_RESET;
		end else if (wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && wb_adr_i == ADDR_CONTROL) begin
			if (wb_sel_i[0]) ctl[7:0] <= wb_dat_i[7:0] & CONTROL_WMASK[7:0];
			if (wb_sel_i[1]) ctl[15:8] <= wb_dat_i[15:8] & CONTROL_WMASK[15:8];
		end
	end
	// synchronisers need three edges before the pin relation holds
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			age  <= 2'h0;
			hi_q <= 1'b0;
			lo_q <= 1'b0;
		end else begin
			hi_q <= pwm_high_side_out_i;
			lo_q <= pwm_low_side_out_i;
			if (age != 2'h3) age <= age + 2'h1;
		end
	end
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);
	// ****************
	// properties
	// ****************
	a_ack_one_cycle: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack longer than one cycle");
	a_ack_after_req: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
		else $error("request not acked next cycle");
	a_no_stray_ack: assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o)
		else $error("ack without request");
	a_dat_upper_zero: assert property (wb_ack_o |-> wb_dat_o[31:16] == 16'h0000)
		else $error("upper read bits not zero");
	a_edge_starts: assert property (trig |-> ##2 leb_active_o)
		else $error("enabled edge did not start blanking");
	a_edge_cause: assert property ($rose(leb_active_o) |-> $past(trig, 2))
		else $error("blanking started without enabled edge");
	a_fault_gate: assert property (age == 2'h3 |-> fault_o == ($past(fault_raw_i, 3)
		&& !($past(ctl[11]) && (leb_active_o || state_blank_o))))
		else $error("fault output wrong");
	a_curlim_gate: assert property (age == 2'h3 |-> curlim_o == ($past(curlim_raw_i, 3)
		&& !($past(ctl[10]) && (leb_active_o || state_blank_o))))
		else $error("current limit output wrong");
	a_state_level: assert property (age == 2'h3 |-> state_blank_o == (
		$past(ctl[5]) && $past(sel_blank_sig_i, 3) || $past(ctl[4]) && !$past(sel_blank_sig_i, 3)
		|| $past(ctl[3]) && $past(pwm_high_side_out_i)
		|| $past(ctl[2]) && !$past(pwm_high_side_out_i)))
		else $error("state blanking wrong");
endmodule
bind pwm_leading_edge_blanking_ctrl pwm_leb_checker u_chk (
	.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i,
	.wb_dat_o, .wb_ack_o, .pwm_high_side_out_i, .pwm_low_side_out_i, .sel_blank_sig_i,
	.fault_raw_i, .curlim_raw_i, .fault_o, .curlim_o, .leb_active_o, .state_blank_o
);

// file: test/pwm_leading_edge_blanking_ctrl_tb.sv
`timescale 1ns/1ps
module pwm_leading_edge_blanking_ctrl_tb
	import pwm_leb_pkg::*;
;
	// ****************
	// bench signals
	// ****************
	logic        clk_i = 1'b0;               // 200 MHz
	logic        rst_i = 1'b1;
	logic        wb_cyc_i = 1'b0;            // bus request
	logic        wb_stb_i = 1'b0;
	logic        wb_we_i = 1'b0;
	logic [7:0]  wb_adr_i = 8'h00;
	logic [3:0]  wb_sel_i = 4'h0;
	logic [31:0] wb_dat_i = 32'h0000_0000;
	logic        pwm_high_side_out_i = 1'b0;
	logic        pwm_low_side_out_i = 1'b0;
	logic        sel_blank_sig_i = 1'b0;
	logic        fault_raw_i = 1'b0;
	logic        curlim_raw_i = 1'b0;
	logic [31:0] wb_dat_o;
	logic        wb_ack_o, fault_o, curlim_o, leb_active_o, state_blank_o;
	logic        probe = 1'b0;               // output sample strobe
	logic [31:0] rd_q[$];                    // expected read data
	logic [1:0]  out_q[$];                   // expected {fault_o, curlim_o}
	int          errors = 0;
	int          compares = 0;
	int          seed = 73662;
	int          dur;                        // blanking length in use
	logic [15:0] cur = 16'h0000;             // expected control value

	always #2.5 clk_i = ~clk_i;

	pwm_leading_edge_blanking_ctrl uut (
		.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i,
		.wb_dat_o, .wb_ack_o, .pwm_high_side_out_i, .pwm_low_side_out_i, .sel_blank_sig_i,
		.fault_raw_i, .curlim_raw_i, .fault_o, .curlim_o, .leb_active_o, .state_blank_o
	);

	// ****************
	// tasks
	// ****************
	task automatic bad(input string m);
		errors++;
		$display("BAD %0t %s", $time, m);
	endtask
	task automatic check_read(input logic [31:0] got);
		logic [31:0] e;
		e = rd_q.pop_front();
		compares++;
		if (got !== e) bad($sformatf("read %h want %h", got, e));
	endtask
	task automatic check_out(input logic [1:0] got);
		logic [1:0] e;
		e = out_q.pop_front();
		compares++;
		if (got !== e) bad($sformatf("outputs %b want %b", got, e));
	endtask
	// one classic cycle; a read notes its data first, upper write bits are noise
	task automatic xfer(input logic we, input logic [7:0] adr, input logic [1:0] sel,
			input logic [15:0] dat, input logic [15:0] exp);
		int n;
		n = 0;
		if (!we) rd_q.push_back({16'h0000, exp});
		@(posedge clk_i);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i  <= we;
		wb_adr_i <= adr;
		wb_sel_i <= {2'h0, sel};
		wb_dat_i <= {16'($random(seed)), dat};
		do begin
			@(posedge clk_i);
			n++;
		end while (wb_ack_o !== 1'b1 && n < 20);
		if (n >= 20) bad("no ack");
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
	endtask
	// wait n edges, then have the outputs of the next cycle compared
	task automatic expect_out(input int n, input logic [1:0] e);
		repeat (n) @(posedge clk_i);
		out_q.push_back(e);
		probe <= 1'b1;
		@(posedge clk_i);
		probe <= 1'b0;
	endtask
	// 0,1 high side, 2,3 low side, else blanking select
	task automatic drive_pin(input int k, input logic v);
		if (k < 2) pwm_high_side_out_i <= v;
		else if (k < 4) pwm_low_side_out_i <= v;
		else sel_blank_sig_i <= v;
	endtask
	task automatic report_and_stop();
		$display("compares %0d errors %0d", compares, errors);
		if (errors == 0 && compares > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	// results taken oldest first as they show
	always @(posedge clk_i) begin
		if (wb_ack_o === 1'b1 && wb_we_i === 1'b0) check_read(wb_dat_o);
		if (probe) check_out({fault_o, curlim_o});
	end

	// hang guard, far above the few hundred cycles needed
	initial begin
		repeat (5000) @(posedge clk_i);
		bad("watchdog expired");
		report_and_stop();
	end

	initial begin
		logic [15:0] v;
		logic [1:0]  s;
		logic [1:0]  m;
		logic        pre;
		repeat (10) @(posedge clk_i);
		rst_i <= 1'b0;
		xfer(1'b0, ADDR_CONTROL, 2'h3, 16'h0000, CONTROL_RESET);
		xfer(1'b0, ADDR_DURATION, 2'h3, 16'h0000, DURATION_RESET);
		xfer(1'b1, 8'h0C, 2'h3, 16'hFFFF, 16'h0000);
		xfer(1'b0, 8'h0C, 2'h3, 16'h0000, 16'h0000);
		$display("test reset values done");
		// random byte lanes, read back through the implemented mask
		for (int i = 0; i < 8; i++) begin
			v = 16'($random(seed));
			s = 2'($random(seed));
			if (s[0]) cur[7:0] = v[7:0] & CONTROL_WMASK[7:0];
			if (s[1]) cur[15:8] = v[15:8] & CONTROL_WMASK[15:8];
			xfer(1'b1, ADDR_CONTROL, s, v, 16'h0000);
			xfer(1'b0, ADDR_CONTROL, 2'h3, 16'h0000, cur);
		end
		dur = 3 + {$random(seed)} % 6;
		xfer(1'b1, ADDR_DURATION, 2'h3, 16'(dur), 16'h0000);
		$display("test register access done");
		// one trigger edge per round; the opposite edge comes first and must do nothing
		fault_raw_i <= 1'b1;
		curlim_raw_i <= 1'b1;
		for (int i = 0; i < 4; i++) begin
			pre = i[0];
			m = {i == 2, i == 1};
			drive_pin(i, !pre);
			xfer(1'b1, ADDR_CONTROL, 2'h3, (16'h8000 >> i) | {4'h0, ~m, 10'h000}, 16'h0000);
			expect_out(10, 2'h3);
			drive_pin(i, pre);
			expect_out(3, 2'h3);
			drive_pin(i, !pre);
			expect_out(2, m);
			expect_out(dur - 3, m);
			expect_out(1, 2'h3);
			$display("test edge trigger %0d done", i);
		end
		// state blanking: active level masks both, other level passes
		for (int k = 0; k < 4; k++) begin
			drive_pin(k < 2 ? 4 : 0, k[0]);
			xfer(1'b1, ADDR_CONTROL, 2'h3, 16'h0C00 | (16'h0020 >> k), 16'h0000);
			expect_out(4, 2'h3);
			drive_pin(k < 2 ? 4 : 0, !k[0]);
			expect_out(3, 2'h0);
			drive_pin(k < 2 ? 4 : 0, k[0]);
			expect_out(3, 2'h3);
			$display("test state blanking %0d done", k);
		end
		// blanking off: inputs pass unchanged
		xfer(1'b1, ADDR_CONTROL, 2'h3, 16'h0000, 16'h0000);
		for (int i = 0; i < 8; i++) begin
			s = 2'($random(seed));
			fault_raw_i <= s[1];
			curlim_raw_i <= s[0];
			expect_out(3, s);
		end
		// status mirrors the settled inputs and outputs, no blanking running
		xfer(1'b0, ADDR_STATUS, 2'h3, 16'h0000, {10'h000, s[0], s[1], s[0], s[1], 2'b00});
		$display("test pass-through done");
		report_and_stop();
	end
endmodule
